// >>> src/scfa_alu.sv
`timescale 1ns/1ns
`default_nettype none
`include "scfa_map.svh"
module scfa_alu #(
  parameter int FIFO_DEPTH = 8,
  parameter int FRAME_LEN  = `SCFA_FRAME_LEN,
  parameter int SUBSEG_LEN = `SCFA_SUBSEG_LEN
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // request from sequencer
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire scfa_pkg::scfa_req_s req,
  // result to sequencer
  output logic                    rsp_valid,
  input  wire logic               rsp_ready,
  output scfa_pkg::scfa_rsp_s     rsp
);
  localparam int RW = $bits(scfa_pkg::scfa_rsp_s);

  // ---------------------------------------------------------------
  // operand views
  // ---------------------------------------------------------------
  logic signed [15:0] a16;
  logic signed [15:0] b16;
  logic signed [31:0] a32;
  logic signed [31:0] b32;
  assign a16 = req.a[15:0];
  assign b16 = req.b[15:0];
  assign a32 = req.a;
  assign b32 = req.b;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] sat16(input logic signed [32:0] v);
    if (v > 33'(signed'(`SCFA_S16_MAX))) begin
      sat16 = `SCFA_S16_MAX;
    end else if (v < 33'(signed'(`SCFA_S16_MIN))) begin
      sat16 = `SCFA_S16_MIN;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  function automatic logic [31:0] sat32(input logic signed [32:0] v);
    if (v > 33'(signed'(`SCFA_S32_MAX))) begin
      sat32 = `SCFA_S32_MAX;
    end else if (v < 33'(signed'(`SCFA_S32_MIN))) begin
      sat32 = `SCFA_S32_MIN;
    end else begin
      sat32 = v[31:0];
    end
  endfunction

  // signed shift by a signed count, both directions
  function automatic logic [31:0] shift32(input logic signed [31:0] v, input logic signed [15:0] n,
                                          input logic left);
    logic [15:0] mag;
    logic        go_left;
    mag = n[15] ? 16'(-n) : n;
    go_left = left ^ n[15];
    if (mag > 16'h001f) begin
      shift32 = go_left ? 32'h00000000 : {32{v[31]}};
    end else if (go_left) begin
      shift32 = v <<< mag[4:0];
    end else begin
      shift32 = v >>> mag[4:0];
    end
  endfunction

  // restoring fractional division, 15 quotient bits
  function automatic logic [15:0] frac_div(input logic [15:0] num, input logic [15:0] den);
    logic [16:0] r;
    logic [15:0] q;
    r = {1'b0, num};
    q = '0;
    for (int i = 0; i < 15; i++) begin
      r = {r[15:0], 1'b0};
      q = {q[14:0], 1'b0};
      if (r >= {1'b0, den}) begin
        r = r - {1'b0, den};
        q[0] = 1'b1;
      end
    end
    frac_div = q;
  endfunction

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  logic signed [31:0] prod;
  logic               both_min;
  logic [31:0]        result;
  assign prod     = a16 * b16;
  assign both_min = (a16 == `SCFA_S16_MIN) && (b16 == `SCFA_S16_MIN);

  always_comb begin
    result = '0;
    case (req.op)
      scfa_pkg::SCFA_OP_ADD:   result = {{16{1'b0}}, sat16(33'(a16) + 33'(b16))};
      scfa_pkg::SCFA_OP_SUB:   result = {{16{1'b0}}, sat16(33'(a16) - 33'(b16))};
      scfa_pkg::SCFA_OP_MULT: begin
        result[15:0] = both_min ? `SCFA_S16_MAX : 16'(prod >>> `SCFA_MULT_SHIFT);
      end
      scfa_pkg::SCFA_OP_MULTR: begin
        result[15:0] = both_min ? `SCFA_S16_MAX
                     : 16'((prod + `SCFA_ROUND_CONST) >>> `SCFA_MULT_SHIFT);
      end
      scfa_pkg::SCFA_OP_ABS: begin
        result[15:0] = (a16 == `SCFA_S16_MIN) ? `SCFA_S16_MAX
                     : (a16[15] ? 16'(-a16) : a16);
      end
      scfa_pkg::SCFA_OP_DIV: begin
        result[15:0] = (a16 == b16) ? `SCFA_S16_MAX : frac_div(a16, b16);
      end
      scfa_pkg::SCFA_OP_LMULT: result = prod <<< 1;
      scfa_pkg::SCFA_OP_LADD:  result = sat32(33'(a32) + 33'(b32));
      scfa_pkg::SCFA_OP_LSUB:  result = sat32(33'(a32) - 33'(b32));
      scfa_pkg::SCFA_OP_DEPOS: result = 32'(a16);
      scfa_pkg::SCFA_OP_EXTR:  result = {{16{1'b0}}, a32[15:0]};
      scfa_pkg::SCFA_OP_SHL:   result[15:0] = 16'(shift32(32'(a16), b16, 1'b1));
      scfa_pkg::SCFA_OP_SHR:   result[15:0] = 16'(shift32(32'(a16), b16, 1'b0));
      scfa_pkg::SCFA_OP_LSHL:  result = shift32(a32, b16, 1'b1);
      scfa_pkg::SCFA_OP_LSHR:  result = shift32(a32, b16, 1'b0);
      scfa_pkg::SCFA_OP_SCALE: begin
        result[15:0] = 16'((32'(a16) >>> `SCFA_SAMPLE_DROP) <<< `SCFA_SAMPLE_LIFT);
      end
      default: result = '0;
    endcase
  end
  // sign-extension of 32-bit constants is done by the sequencer on b

  // ---------------------------------------------------------------
  // frame position for sample scaling
  // ---------------------------------------------------------------
  logic [7:0] sample_reg;
  logic       fire;
  logic       is_sample;
  assign fire      = req_valid && req_ready;
  assign is_sample = (req.op == scfa_pkg::SCFA_OP_SCALE);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sample_reg <= 8'h00;
    end else if (fire && is_sample) begin
      sample_reg <= (sample_reg == 8'(FRAME_LEN - 1)) ? 8'h00 : sample_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  scfa_pkg::scfa_rsp_s stage_reg;
  logic                stage_valid_reg;
  logic                fifo_ready;

  assign req_ready = fifo_ready || !stage_valid_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage_valid_reg <= 1'b0;
    end else if (req_ready) begin
      stage_valid_reg <= req_valid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage_reg <= '0;
    end else if (fire) begin
      stage_reg.value      <= result;
      stage_reg.sample_idx <= is_sample ? sample_reg : 8'h00;
      stage_reg.subseg     <= is_sample ? 2'(sample_reg / 8'(SUBSEG_LEN)) : 2'h0;
      stage_reg.frame_end  <= is_sample && (sample_reg == 8'(FRAME_LEN - 1));
    end
  end

  scfa_fifo #(
    .WIDTH (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (stage_valid_reg),
    .in_ready  (fifo_ready),
    .in_data   (stage_reg),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp)
  );
endmodule // scfa_alu
`default_nettype wire

// >>> src/scfa_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module scfa_fifo #(
  parameter int WIDTH = 43,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // scfa_fifo
`default_nettype wire

// >>> src/scfa_map.svh
`ifndef SCFA_MAP_SVH
`define SCFA_MAP_SVH
`define SCFA_S16_MAX       16'sh7fff
`define SCFA_S16_MIN       16'sh8000
`define SCFA_S32_MAX       32'sh7fffffff
`define SCFA_S32_MIN       32'sh80000000
`define SCFA_MULT_SHIFT    15
`define SCFA_ROUND_CONST   32'sh00004000
`define SCFA_SAMPLE_DROP   3
`define SCFA_SAMPLE_LIFT   2
`define SCFA_FRAME_LEN     160
`define SCFA_SUBSEG_LEN    40
`define SCFA_SUBSEG_COUNT  4
`define SCFA_LATENCY       1
`endif

// >>> src/scfa_pkg.sv
package scfa_pkg;
  typedef enum logic [3:0] {
    SCFA_OP_ADD    = 4'h0,
    SCFA_OP_SUB    = 4'h1,
    SCFA_OP_MULT   = 4'h2,
    SCFA_OP_MULTR  = 4'h3,
    SCFA_OP_ABS    = 4'h4,
    SCFA_OP_DIV    = 4'h5,
    SCFA_OP_LMULT  = 4'h6,
    SCFA_OP_LADD   = 4'h7,
    SCFA_OP_LSUB   = 4'h8,
    SCFA_OP_DEPOS  = 4'h9,
    SCFA_OP_EXTR   = 4'ha,
    SCFA_OP_SHL    = 4'hb,
    SCFA_OP_SHR    = 4'hc,
    SCFA_OP_LSHL   = 4'hd,
    SCFA_OP_LSHR   = 4'he,
    SCFA_OP_SCALE  = 4'hf
  } scfa_op_e;

  typedef struct packed {
    scfa_op_e    op;
    logic [31:0] a;
    logic [31:0] b;
  } scfa_req_s;

  typedef struct packed {
    logic [31:0] value;
    logic [7:0]  sample_idx;
    logic [1:0]  subseg;
    logic        frame_end;
  } scfa_rsp_s;
endpackage

// >>> test/scfa_alu_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module scfa_alu_asserts #(
  parameter int FIFO_DEPTH = 8,
  parameter int FRAME_LEN  = 160,
  parameter int SUBSEG_LEN = 40
) (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst,
  // request
  input wire logic                req_valid,
  input wire logic                req_ready,
  input wire scfa_pkg::scfa_req_s req,
  // result
  input wire logic                rsp_valid,
  input wire logic                rsp_ready,
  input wire scfa_pkg::scfa_rsp_s rsp
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ----
  // occupancy of stage and fifo
  // ----
  logic [4:0] pend_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= 5'h0;
    end else begin
      pend_reg <= pend_reg + 5'(req_valid && req_ready) - 5'(rsp_valid && rsp_ready);
    end
  end
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_stall;
    rsp_valid && !rsp_ready;
  endsequence
  // ----
  // properties
  // ----
  a_reset_clean: assert property ($fell(rst) |-> req_ready && !rsp_valid)
    else $error("not idle after reset");
  a_take_answer: assert property (s_take |-> ##[1:2] rsp_valid)
    else $error("no result after request");
  a_first_wait: assert property (s_take ##0 pend_reg == 5'h0 |=> !rsp_valid)
    else $error("result too early");
  a_rsp_holds: assert property (s_stall |=> rsp_valid && $stable(rsp))
    else $error("result moved while stalled");
  a_refuse_full: assert property (!req_ready |-> pend_reg == 5'(FIFO_DEPTH + 1))
    else $error("refused while not full");
  a_no_phantom: assert property (rsp_valid |-> pend_reg != 5'h0)
    else $error("result without request");
  a_frame_close: assert property (rsp_valid && rsp.frame_end |->
    rsp.sample_idx == 8'(FRAME_LEN - 1) && rsp.subseg == 2'((FRAME_LEN - 1) / SUBSEG_LEN))
    else $error("frame end misplaced");
  a_subseg_idx: assert property (rsp_valid |->
    rsp.sample_idx < FRAME_LEN && rsp.subseg == 2'(rsp.sample_idx / SUBSEG_LEN))
    else $error("sub-segment mismatch");
endmodule // scfa_alu_asserts
bind scfa_alu scfa_alu_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .FRAME_LEN(FRAME_LEN), .SUBSEG_LEN(SUBSEG_LEN)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
`default_nettype wire

// >>> test/scfa_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module scfa_seq_model (
  // clock
  input  wire logic                ref_clk,
  // request side
  output logic                     req_valid,
  input  wire logic                req_ready,
  output scfa_pkg::scfa_req_s      req,
  // result side
  input  wire logic                rsp_valid,
  output logic                     rsp_ready,
  input  wire scfa_pkg::scfa_rsp_s rsp
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    rsp_ready = 1'b0;
  end
  // hold request until taken
  task automatic send(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
    @(negedge ref_clk);
    req_valid = 1'b1;
    req = '{scfa_pkg::scfa_op_e'(op), a, b};
    do @(posedge ref_clk); while (req_ready !== 1'b1);
  endtask
  // released operands show inverted data
  task automatic idle;
    @(negedge ref_clk);
    req_valid = 1'b0;
    req.a = ~req.a;
    req.b = ~req.b;
  endtask
  task automatic take(input int stall, output scfa_pkg::scfa_rsp_s r);
    repeat (stall) @(negedge ref_clk);
    @(negedge ref_clk);
    rsp_ready = 1'b1;
    do @(posedge ref_clk); while (rsp_valid !== 1'b1);
    r = rsp;
    @(negedge ref_clk);
    rsp_ready = 1'b0;
  endtask
endmodule // scfa_seq_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  logic                req_valid;
  logic                req_ready;
  logic                rsp_valid;
  logic                rsp_ready;
  scfa_pkg::scfa_req_s req;
  scfa_pkg::scfa_rsp_s rsp;
  scfa_pkg::scfa_rsp_s got;
  int                  failures = 0;
  int                  n_tests = 0;
  int                  cyc = 0;
  always #50 ref_clk = ~ref_clk;
  scfa_alu u_dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
  scfa_seq_model u_seq (.ref_clk(ref_clk), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
  task automatic stop_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_pos(input logic [10:0] g, input logic [10:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t position %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] e);
    u_seq.send(op, a, b);
    u_seq.idle();
    u_seq.take(0, got);
    cmp(got.value, e);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_frame;
    for (int k = 0; k < 160; k++) begin
      run(4'hf, 32'(k * 8 + k % 8), 32'h0, 32'(k * 4));
      cmp_pos({got.sample_idx, got.subseg, got.frame_end}, {8'(k), 2'(k / 40), k == 159});
    end
  endtask
  task automatic t_ops;
    run(4'h0, 32'h7fff, 32'h1, 32'h7fff);
    run(4'h0, 32'h8000, 32'hffff, 32'h8000);
    run(4'h1, 32'h8000, 32'h1, 32'h8000);
    run(4'h2, 32'h8000, 32'h8000, 32'h7fff);
    run(4'h2, 32'hc000, 32'h4000, 32'he000);
    run(4'h3, 32'h8000, 32'h8000, 32'h7fff);
    run(4'h3, 32'h1, 32'h4000, 32'h1);
    run(4'h4, 32'h8000, 32'h0, 32'h7fff);
    run(4'h4, 32'hfff6, 32'h0, 32'ha);
    run(4'h5, 32'h1234, 32'h1234, 32'h7fff);
    run(4'h5, 32'h1, 32'h3, 32'h2aaa);
    run(4'h6, 32'h4000, 32'h4000, 32'h20000000);
    run(4'h7, 32'h7fffffff, 32'h1, 32'h7fffffff);
    run(4'h7, 32'h80000000, 32'hffffffff, 32'h80000000);
    run(4'h8, 32'h80000000, 32'h1, 32'h80000000);
    run(4'h9, 32'habcd8001, 32'h0, 32'hffff8001);
    run(4'ha, 32'h12348765, 32'h0, 32'h8765);
    run(4'hb, 32'hfff8, 32'hfffffffe, 32'hfffe);
    run(4'hc, 32'h8000, 32'h4, 32'hf800);
    run(4'hc, 32'h3, 32'hfffffffe, 32'hc);
    run(4'hd, 32'h40000001, 32'h1, 32'h80000002);
    run(4'he, 32'h80000000, 32'h1f, 32'hffffffff);
    run(4'hf, 32'h8007, 32'h0, 32'hc000);
  endtask
  task automatic t_fill;
    for (int k = 0; k < 9; k++) begin
      u_seq.send(4'h0, 32'(k), 32'h0);
    end
    u_seq.idle();
    cmp(32'(req_ready), 32'h0);
    fork
      begin
        u_seq.send(4'h0, 32'h9, 32'h0);
        u_seq.idle();
      end
    join_none
    for (int k = 0; k < 10; k++) begin
      u_seq.take(k % 2, got);
      cmp(got.value, 32'(k));
    end
    cmp(32'(rsp_valid), 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    cmp({30'h0, req_ready, rsp_valid}, 32'h2);
    t_frame();
    t_ops();
    t_fill();
    stop_test();
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end
endmodule // tb_top
`default_nettype wire
